// ---- rtl/pll_synth_pkg.sv ----
/*
 * constants, field layout, reset values and helpers of the synthesizer core.
 * assumes a 20 MHz system clock and byte addresses on a 32-bit register bus.
 */
package pll_synth_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REF_CNT_W = 14;
    localparam int unsigned NDIV_W = 14;
    localparam int unsigned FB_CNT_W = 15;
    localparam int unsigned EVT_W = 3;
    localparam int unsigned PULSE_CNT_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_NDIV = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DETECT = 5'h10;

    // fields
    localparam int unsigned CTRL_REF_SEL_LSB = 0;
    localparam int unsigned CTRL_TXRX_BIT = 3;
    localparam int unsigned EVT_LOCK_LOST = 0;
    localparam int unsigned EVT_REF_TICK = 1;
    localparam int unsigned EVT_FB_TICK = 2;
    localparam int unsigned DETECT_LOCK_BIT = 0;
    localparam int unsigned DETECT_REF_LEAD_BIT = 1;
    localparam int unsigned DETECT_FB_LEAD_BIT = 2;
    localparam int unsigned DETECT_EFF_LSB = 16;

    // reset values: open select pins read as ones
    localparam logic [3:0] CTRL_RESET = 4'hF;
    localparam logic [NDIV_W-1:0] NDIV_RESET = 14'h3FFF;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
    localparam logic [FB_CNT_W-1:0] TXRX_OFFSET = 15'h0358;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_FREQ_MHZ = 20;
    localparam int unsigned MIN_PULSE_NS = 100;
    localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////
    // reference divide ratio per select code
    function automatic logic [REF_CNT_W-1:0] ref_ratio(input logic [2:0] sel);
        case (sel)
            3'h0: ref_ratio = 14'h0008;
            3'h1: ref_ratio = 14'h0080;
            3'h2: ref_ratio = 14'h0100;
            3'h3: ref_ratio = 14'h0200;
            3'h4: ref_ratio = 14'h0400;
            3'h5: ref_ratio = 14'h0800;
            3'h6: ref_ratio = 14'h096A;
            default: ref_ratio = 14'h2000;
        endcase
    endfunction

endpackage

// ---- rtl/pfd_link_if.sv ----
/*
 * carrier between the divider core and the phase detector.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface pfd_link_if;
    logic ref_tick;
    logic fb_tick;
    logic ref_lead;
    logic fb_lead;
    logic both_low;
    logic locked;

    modport core (
        output ref_tick,
        output fb_tick,
        input ref_lead,
        input fb_lead,
        input both_low,
        input locked
    );

    modport det (
        input ref_tick,
        input fb_tick,
        output ref_lead,
        output fb_lead,
        output both_low,
        output locked
    );
endinterface

// ---- rtl/phase_detector.sv ----
/*
 * phase/frequency detector on compare ticks of one system clock cycle.
 * assumes ticks come from flip-flops of the same clock domain.
 */
`timescale 1ns/1ps
module phase_detector
    import pll_synth_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    pfd_link_if.det link
);

    typedef struct packed {
        logic ref_lead;
        logic fb_lead;
        logic [PULSE_CNT_W-1:0] pulse_cnt;
    } pfd_state_t;

    pfd_state_t state_reg;
    pfd_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // edge compare
    always_comb begin
        logic ref_seen;
        logic fb_seen;
        ref_seen = state_reg.ref_lead | link.ref_tick;
        fb_seen = state_reg.fb_lead | link.fb_tick;
        state_next = state_reg;
        if (ref_seen && fb_seen) begin
            // both edges in: clear and issue the minimum pulse
            state_next.ref_lead = 1'b0;
            state_next.fb_lead = 1'b0;
            state_next.pulse_cnt = PULSE_CNT_W'(MIN_PULSE_CYC);
        end else begin
            // first edge opens the error pulse
            state_next.ref_lead = ref_seen;
            state_next.fb_lead = fb_seen;
            if (state_reg.pulse_cnt != '0) begin
                state_next.pulse_cnt = state_reg.pulse_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.ref_lead = state_reg.ref_lead;
    assign link.fb_lead = state_reg.fb_lead;
    assign link.both_low = state_reg.pulse_cnt != '0;
    // locked while no edge waits for its partner
    assign link.locked = ~(state_reg.ref_lead | state_reg.fb_lead);

endmodule

// ---- rtl/pll_synth_core.sv ----
/*
 * synthesizer core: reference and feedback dividers, detector outputs,
 * lock indicator, register slave and interrupt.
 * assumes an avalon-mm master on clock_i and asynchronous reference and vco pins.
 */
// Local design decisions: the register offsets and the Avalon-MM register port.
// Function
// - select code picks one of eight reference ratios
// - feedback divider reloads at zero, keeps counting
// - feedback value is 14 bits, bit 0 lsb
// - add 856 while transmit/receive select low
// - single-ended output pulses low when feedback leads
// - single-ended output pulses high when feedback lags
// - single-ended output floats when locked
// - vco-lead output pulses low when feedback leads
// - reference-lead output pulses low when feedback lags
// - locked: both outputs high, brief joint low
// - buffered feedback divider output on its own pin
// - lock indicator high when locked, pulses low otherwise
// - feedback divider advances on vco rising edges
`timescale 1ns/1ps
module pll_synth_core
    import pll_synth_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [pll_synth_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pll_synth_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [pll_synth_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic reference_clock_input_i,
    input wire logic vco_frequency_i,
    output logic single_ended_phase_error_o,
    output logic single_ended_phase_error_oe_o,
    output logic vco_lead_n_o,
    output logic ref_lead_n_o,
    output logic lock_indicator_o,
    output logic feedback_compare_clock_o,
    output logic irq_o
);

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus_state;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic [3:0] ctrl;
        logic [NDIV_W-1:0] ndiv;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic ref_meta;
        logic ref_sync;
        logic ref_prev;
        logic vco_meta;
        logic vco_sync;
        logic vco_prev;
        logic [REF_CNT_W-1:0] ref_cnt;
        logic [FB_CNT_W-1:0] fb_cnt;
        logic ref_tick;
        logic fb_tick;
        logic fb_out;
        logic pd_out;
        logic pd_oe;
        logic vlead_n;
        logic rlead_n;
        logic lock;
        logic irq;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    pfd_link_if link ();

    phase_detector phase_detector_i (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .link(link)
    );

    assign link.ref_tick = state_reg.ref_tick;
    assign link.fb_tick = state_reg.fb_tick;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_value,
        input logic [DATA_W-1:0] new_value,
        input logic [3:0] byte_en
    );
        logic [DATA_W-1:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (byte_en[i]) begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    function automatic logic rising(input logic now_level, input logic prev_level);
        return now_level & ~prev_level;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [FB_CNT_W-1:0] eff_div;
        logic [2:0] ref_sel;
        logic [EVT_W-1:0] events;
        logic [EVT_W-1:0] clear_bits;
        logic [DATA_W-1:0] wr_word;
        logic access;
        logic commit_wr;
        logic ref_rise;
        logic vco_rise;

        eff_div = '0;
        ref_sel = '0;
        events = '0;
        clear_bits = '0;
        wr_word = '0;
        access = avs_read_i | avs_write_i;
        commit_wr = 1'b0;
        ref_rise = 1'b0;
        vco_rise = 1'b0;
        state_next = state_reg;

        // pin synchronisers
        state_next.ref_meta = reference_clock_input_i;
        state_next.ref_sync = state_reg.ref_meta;
        state_next.ref_prev = state_reg.ref_sync;
        state_next.vco_meta = vco_frequency_i;
        state_next.vco_sync = state_reg.vco_meta;
        state_next.vco_prev = state_reg.vco_sync;
        ref_rise = rising(state_reg.ref_sync, state_reg.ref_prev);
        vco_rise = rising(state_reg.vco_sync, state_reg.vco_prev);

        // reference divider
        ref_sel = state_reg.ctrl[CTRL_REF_SEL_LSB +: 3];
        state_next.ref_tick = 1'b0;
        if (ref_rise) begin
            if (state_reg.ref_cnt <= REF_CNT_W'(1)) begin
                state_next.ref_cnt = ref_ratio(ref_sel);
                state_next.ref_tick = 1'b1;
            end else begin
                state_next.ref_cnt = state_reg.ref_cnt - 1'b1;
            end
        end

        // feedback divider with transmit/receive offset
        eff_div = {1'b0, state_reg.ndiv};
        if (!state_reg.ctrl[CTRL_TXRX_BIT]) begin
            eff_div = eff_div + TXRX_OFFSET;
        end
        state_next.fb_tick = 1'b0;
        if (vco_rise) begin
            state_next.fb_out = 1'b0;
            if (state_reg.fb_cnt <= FB_CNT_W'(1)) begin
                state_next.fb_cnt = eff_div;
                state_next.fb_tick = 1'b1;
                state_next.fb_out = 1'b1;
            end else begin
                state_next.fb_cnt = state_reg.fb_cnt - 1'b1;
            end
        end

        // detector pins
        if (link.fb_lead && !link.ref_lead) begin
            state_next.pd_oe = 1'b1;
            state_next.pd_out = 1'b0;
        end else if (link.ref_lead && !link.fb_lead) begin
            state_next.pd_oe = 1'b1;
            state_next.pd_out = 1'b1;
        end else begin
            state_next.pd_oe = 1'b0;
            state_next.pd_out = 1'b0;
        end
        state_next.vlead_n = ~(link.fb_lead | link.both_low);
        state_next.rlead_n = ~(link.ref_lead | link.both_low);
        state_next.lock = link.locked;

        // sticky events, set wins over clear
        events[EVT_LOCK_LOST] = state_reg.lock & ~link.locked;
        events[EVT_REF_TICK] = state_reg.ref_tick;
        events[EVT_FB_TICK] = state_reg.fb_tick;

        // register slave: one wait state, then the access completes
        case (state_reg.bus_state)
            BUS_IDLE: begin
                state_next.waitrequest = 1'b1;
                if (access) begin
                    state_next.bus_state = BUS_DONE;
                    state_next.waitrequest = 1'b0;
                    state_next.readdata = '0;
                    if (avs_read_i) begin
                        if (avs_address_i == ADDR_CTRL) begin
                            state_next.readdata = DATA_W'(state_reg.ctrl);
                        end else if (avs_address_i == ADDR_NDIV) begin
                            state_next.readdata = DATA_W'(state_reg.ndiv);
                        end else if (avs_address_i == ADDR_STATUS) begin
                            state_next.readdata = DATA_W'(state_reg.status);
                        end else if (avs_address_i == ADDR_MASK) begin
                            state_next.readdata = DATA_W'(state_reg.mask);
                        end else if (avs_address_i == ADDR_DETECT) begin
                            state_next.readdata[DETECT_LOCK_BIT] = state_reg.lock;
                            state_next.readdata[DETECT_REF_LEAD_BIT] = link.ref_lead;
                            state_next.readdata[DETECT_FB_LEAD_BIT] = link.fb_lead;
                            state_next.readdata[DETECT_EFF_LSB +: FB_CNT_W] = eff_div;
                        end else begin
                            state_next.readdata = '0;
                        end
                    end
                end
            end
            BUS_DONE: begin
                state_next.bus_state = BUS_IDLE;
                state_next.waitrequest = 1'b1;
                commit_wr = avs_write_i;
            end
            default: begin
                state_next.bus_state = BUS_IDLE;
                state_next.waitrequest = 1'b1;
            end
        endcase

        if (commit_wr) begin
            if (avs_address_i == ADDR_CTRL) begin
                wr_word = merge_bytes(DATA_W'(state_reg.ctrl), avs_writedata_i, avs_byteenable_i);
                state_next.ctrl = wr_word[3:0];
            end else if (avs_address_i == ADDR_NDIV) begin
                wr_word = merge_bytes(DATA_W'(state_reg.ndiv), avs_writedata_i, avs_byteenable_i);
                state_next.ndiv = wr_word[NDIV_W-1:0];
            end else if (avs_address_i == ADDR_STATUS) begin
                wr_word = merge_bytes('0, avs_writedata_i, avs_byteenable_i);
                clear_bits = wr_word[EVT_W-1:0];
            end else if (avs_address_i == ADDR_MASK) begin
                wr_word = merge_bytes(DATA_W'(state_reg.mask), avs_writedata_i, avs_byteenable_i);
                state_next.mask = wr_word[EVT_W-1:0];
            end else begin
                wr_word = '0;
            end
        end

        state_next.status = (state_reg.status & ~clear_bits) | events;
        state_next.irq = |(state_next.status & state_next.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.bus_state <= BUS_IDLE;
            state_reg.waitrequest <= 1'b1;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.ndiv <= NDIV_RESET;
            state_reg.mask <= MASK_RESET;
            state_reg.vlead_n <= 1'b1;
            state_reg.rlead_n <= 1'b1;
            state_reg.lock <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_readdata_o = state_reg.readdata;
    assign avs_waitrequest_o = state_reg.waitrequest;
    assign single_ended_phase_error_o = state_reg.pd_out;
    assign single_ended_phase_error_oe_o = state_reg.pd_oe;
    assign vco_lead_n_o = state_reg.vlead_n;
    assign ref_lead_n_o = state_reg.rlead_n;
    assign lock_indicator_o = state_reg.lock;
    assign feedback_compare_clock_o = state_reg.fb_out;
    assign irq_o = state_reg.irq;

endmodule

// ---- tb/pll_synth_core_asserts.sv ----
/* checker of bus handshake and detector outputs.
   assumes it is bound into the synthesizer core top. */
`timescale 1ns/1ps
module pll_synth_core_asserts (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic single_ended_phase_error_o,
    input wire logic single_ended_phase_error_oe_o,
    input wire logic vco_lead_n_o,
    input wire logic ref_lead_n_o,
    input wire logic lock_indicator_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one wait");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    wait_idle_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("answer without request");
    fb_lead_a: assert property (
        !vco_lead_n_o && ref_lead_n_o |-> single_ended_phase_error_oe_o && !single_ended_phase_error_o)
        else $error("feedback lead not driven low");
    ref_lead_a: assert property (
        !ref_lead_n_o && vco_lead_n_o |-> single_ended_phase_error_oe_o && single_ended_phase_error_o)
        else $error("feedback lag not driven high");
    joint_float_a: assert property (
        !vco_lead_n_o && !ref_lead_n_o |-> !single_ended_phase_error_oe_o)
        else $error("single output driven during joint pulse");
    joint_width_a: assert property (
        $rose(!vco_lead_n_o && !ref_lead_n_o) |=> (!vco_lead_n_o && !ref_lead_n_o) ##1 (vco_lead_n_o || ref_lead_n_o))
        else $error("joint pulse not two cycles");
    lock_lead_a: assert property (
        !lock_indicator_o |-> single_ended_phase_error_oe_o && (vco_lead_n_o != ref_lead_n_o))
        else $error("lock low without one lead");
    lock_float_a: assert property (
        lock_indicator_o |-> !single_ended_phase_error_oe_o)
        else $error("single output driven while locked");
endmodule
bind pll_synth_core pll_synth_core_asserts pll_synth_core_asserts_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .single_ended_phase_error_o(single_ended_phase_error_o),
    .single_ended_phase_error_oe_o(single_ended_phase_error_oe_o),
    .vco_lead_n_o(vco_lead_n_o), .ref_lead_n_o(ref_lead_n_o), .lock_indicator_o(lock_indicator_o));

// ---- tb/pll_partner.sv ----
/* reference oscillator and vco model, 400 ns period, one shared phase.
   assumes the bench gates each source and may slip the vco by whole periods. */
`timescale 1ns/1ps
module pll_partner (
    input wire logic ref_run_i,
    input wire logic vco_run_i,
    output logic ref_pin_o,
    output logic vco_pin_o
);
    logic phase;
    logic hold;
    int skip_n;
    initial begin
        phase = 1'b0;
        hold = 1'b0;
        skip_n = 0;
        ref_pin_o = 1'b0;
        vco_pin_o = 1'b0;
        #13;
        forever begin
            #200;
            phase = ~phase;
        end
    end
    // pins move only at half periods, so no pulse is cut short
    always @(phase) begin
        if (phase && skip_n > 0) begin
            hold = 1'b1;
            skip_n--;
        end else if (phase) begin
            hold = 1'b0;
        end
        ref_pin_o = phase & ref_run_i;
        vco_pin_o = phase & vco_run_i & ~hold;
    end
    task automatic skip_one();
        skip_n++;
    endtask
endmodule

// ---- tb/parallel_pll_synth_core_bench.sv ----
/* self-checking bench of the synthesizer core.
   assumes the partner model drives both pins and the checker is bound. */
`timescale 1ns/1ps
module parallel_pll_synth_core_bench;
    import pll_synth_pkg::*;
    logic clock_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [ADDR_W-1:0] avs_address_i, mon_addr;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic ref_pin, vco_pin, ref_run, vco_run, pd, pd_oe, vco_lead_n, ref_lead_n, lock, fb_clk, irq;
    int num_errors, tests_run, cyc, c, k, r, l0, fbo, rfo, bl, ll, oeh;
    int nv[3];
    logic [DATA_W-1:0] exp_q[$];
    logic [ADDR_W-1:0] addr_q[$];
    pll_synth_core pll_synth_core_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .reference_clock_input_i(ref_pin), .vco_frequency_i(vco_pin),
        .single_ended_phase_error_o(pd), .single_ended_phase_error_oe_o(pd_oe), .vco_lead_n_o(vco_lead_n),
        .ref_lead_n_o(ref_lead_n), .lock_indicator_o(lock), .feedback_compare_clock_o(fb_clk), .irq_o(irq));
    pll_partner pll_partner_i (.ref_run_i(ref_run), .vco_run_i(vco_run), .ref_pin_o(ref_pin), .vco_pin_o(vco_pin));
    ////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            final_report();
        end
    end
    // read monitor takes the oldest note
    always @(posedge clock_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("read queue", 0, 1);
            end else begin
                mon_addr = addr_q.pop_front();
                check($sformatf("reg %h", mon_addr), exp_q.pop_front(), avs_readdata_o);
            end
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= !w;
        avs_write_i <= w;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        check("wait cycles", 2, n);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_q.push_back(a);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask
    task automatic fb_rise(output int n);
        logic p;
        n = 0;
        do begin
            p = fb_clk;
            @(posedge clock_i);
            n++;
        end while (!(p === 1'b0 && fb_clk === 1'b1) && n < 20000);
    endtask
    task automatic watch(input int n);
        fbo = 0;
        rfo = 0;
        bl = 0;
        ll = 0;
        oeh = 0;
        repeat (n) begin
            @(posedge clock_i);
            if (vco_lead_n === 1'b0 && ref_lead_n === 1'b1) fbo++;
            if (vco_lead_n === 1'b1 && ref_lead_n === 1'b0) rfo++;
            if (vco_lead_n === 1'b0 && ref_lead_n === 1'b0) bl++;
            if (lock === 1'b0) ll++;
            if (pd_oe === 1'b1) oeh++;
        end
    endtask
    task automatic fb_period(input int e);
        fb_rise(c);
        fb_rise(c);
        fb_rise(c);
        check("fb period", 32'(e * 8), 32'(c));
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        sys_rst_i = 1'b1;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = '0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'hF;
        ref_run = 1'b0;
        vco_run = 1'b0;
        c = $urandom(32'h1dd8_0b08);
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(ADDR_CTRL, 32'h0000_000F);
        rd(ADDR_MASK, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        rd(5'h14, 32'h0000_0000);
        bus(1'b1, ADDR_NDIV, 32'h0000_1234, 4'h1);
        rd(ADDR_NDIV, 32'h0000_3F34);
        rd(ADDR_DETECT, 32'h3F34_0001);
        $display("test registers done");
        // divide values kept within 3..22
        nv[0] = 3;
        nv[1] = 3 + ($urandom % 20);
        nv[2] = 12;
        wr(ADDR_CTRL, 32'h0000_0008);
        for (k = 0; k < 3; k++) begin
            wr(ADDR_NDIV, 32'(nv[k]));
            ref_run <= 1'b1;
            vco_run <= 1'b1;
            fb_period(nv[k]);
        end
        $display("test feedback divider done");
        wr(ADDR_NDIV, 32'h0000_0004);
        repeat (200) @(posedge clock_i);
        watch(320);
        check("fb lead", 1, fbo > 0);
        check("ref lead", 0, rfo);
        check("lock low", 1, ll > 0);
        wr(ADDR_NDIV, 32'h0000_0010);
        repeat (300) @(posedge clock_i);
        watch(320);
        check("ref lead", 1, rfo > 0);
        check("fb lead", 0, fbo);
        $display("test detector done");
        for (k = 0; k < 3; k++) begin
            r = (k == 0) ? 8 : (128 << (k - 1));
            wr(ADDR_CTRL, 32'(k + 8));
            wr(ADDR_NDIV, 32'(r));
            repeat (r * 24) @(posedge clock_i);
            watch(r * 8);
            l0 = ll;
            watch(r * 8);
            check("lock pattern", 32'(l0), 32'(ll));
        end
        $display("test reference ratios done");
        wr(ADDR_CTRL, 32'h0000_0008);
        wr(ADDR_NDIV, 32'h0000_0008);
        repeat (2100) @(posedge clock_i);
        for (k = 0; k < 10; k++) begin
            watch(128);
            if (ll == 0) break;
            pll_partner_i.skip_one();
            repeat (100) @(posedge clock_i);
        end
        watch(320);
        check("lock held", 0, ll);
        check("output floating", 0, oeh);
        check("joint low cycles", 10, bl);
        $display("test lock done");
        ref_run <= 1'b0;
        vco_run <= 1'b0;
        repeat (20) @(posedge clock_i);
        wr(ADDR_MASK, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_0007);
        rd(ADDR_STATUS, 32'h0000_0000);
        check("irq", 0, irq);
        vco_run <= 1'b1;
        repeat (100) @(posedge clock_i);
        check("irq masked", 0, irq);
        wr(ADDR_MASK, 32'h0000_0004);
        repeat (3) @(posedge clock_i);
        check("irq raised", 1, irq);
        rd(ADDR_MASK, 32'h0000_0004);
        vco_run <= 1'b0;
        repeat (20) @(posedge clock_i);
        wr(ADDR_STATUS, 32'h0000_0007);
        repeat (3) @(posedge clock_i);
        check("irq cleared", 0, irq);
        vco_run <= 1'b1;
        repeat (100) @(posedge clock_i);
        check("irq again", 1, irq);
        rd(ADDR_STATUS, 32'h0000_0004);
        wr(ADDR_MASK, 32'h0000_0000);
        ref_run <= 1'b1;
        $display("test interrupt done");
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_NDIV, 32'h0000_0003);
        fb_period(859);
        $display("test offset done");
        repeat (2) @(posedge clock_i);
        final_report();
    end
endmodule
